// >>> pfc_cap_edge.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_cap_edge
   import pfc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // pin and polarity
   input wire logic pin,
   input wire logic invert,
   // one-cycle events
   output logic rise,
   output logic fall
);

   logic sync_a;
   logic sync_b;
   logic prev;
   logic up_raw;
   logic down_raw;

   // two-stage synchroniser, then one history sample
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev <= 1'b0;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
         prev <= sync_b;
      end
   end

   // compare consecutive samples: a level cannot both rise and fall
   assign up_raw = sync_b & ~prev;
   assign down_raw = ~sync_b & prev;

   // inversion swaps the event kind instead of the data path, so a
   // change of the invert bit never fakes an edge
   assign rise = invert ? down_raw : up_raw;
   assign fall = invert ? up_raw : down_raw;

   chk_edge_single: assert property (
      @(posedge clk) disable iff (!rstn) !(rise && fall))
      else $error("rise and fall in one cycle");

   chk_invert_swap: assert property (
      @(posedge clk) disable iff (!rstn)
      (invert && $fell(sync_b)) |-> rise)
      else $error("inverted falling pin did not give rise");

endmodule
`default_nettype wire

// >>> pfc_capture_top.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_capture_top
   import pfc_pkg::*;
#(
   parameter bit LOW_DENSITY = 1'b0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // avalon-mm slave
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // pwm counter side, same clock
   input wire logic [15:0] cnt_ch0,
   input wire logic [15:0] cnt_ch1,
   input wire logic [3:0] zero_hit,
   // capture pins, asynchronous
   input wire logic [1:0] cap_pin,
   // interrupt requests
   output logic [3:0] period_irq,
   output logic [1:0] capture_irq
);

   logic req;
   logic ack;
   logic wr_go;
   logic [3:0] period_ie;
   logic legacy_compat_select;
   logic [3:0] period_flags;
   logic [3:0] period_clr;
   logic clr_level;
   logic [3:0] ctl [2];
   logic [1:0] capif;
   logic [1:0] rind;
   logic [1:0] find;
   logic [PFC_CNT_W-1:0] rise_snap [2];
   logic [PFC_CNT_W-1:0] fall_snap [2];
   logic [PFC_CNT_W-1:0] cnt [2];
   logic [1:0] rise_raw;
   logic [1:0] fall_raw;
   logic [1:0] rise_ev;
   logic [1:0] fall_ev;
   logic [1:0] capif_set;
   logic [1:0] capif_clr;
   logic [1:0] rind_clr;
   logic [1:0] find_clr;
   logic [31:0] ccr_word;

   // true when the accepted write targets ofs and its byte lane is enabled
   function automatic logic wr_lane(input logic [7:0] ofs, input int lane);
      wr_lane = wr_go && (avs_address == ofs) && avs_byteenable[lane];
   endfunction

   assign cnt[0] = cnt_ch0;
   assign cnt[1] = cnt_ch1;

   // one wait state: register read data first, then release the master
   assign req = avs_read | avs_write;
   assign avs_waitrequest = req & ~ack;
   assign wr_go = avs_write & ack;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ack <= 1'b0;
      end else begin
         ack <= req & ~ack;
      end
   end

   // period interrupt enables
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         period_ie <= PFC_RST_PERIOD;
      end else if (wr_lane(PFC_OFS_PERIOD_IE, 0)) begin
         period_ie <= avs_writedata[3:0];
      end
   end

   // legacy select exists only in the low-density build, else reads zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         legacy_compat_select <= 1'b0;
      end else if (LOW_DENSITY && wr_lane(PFC_OFS_LEGACY, 0)) begin
         legacy_compat_select <= avs_writedata[0];
      end
   end

   // period flags, cleared by writing ones
   assign period_clr = wr_lane(PFC_OFS_PERIOD_FLAGS, 0) ? avs_writedata[3:0] : 4'h0;

   pfc_period_flags u_period_flags (
      .clk(clk),
      .rstn(rstn),
      .set_pulse(zero_hit),
      .clr_mask(period_clr),
      .flags(period_flags)
   );

   // registered so the request line never glitches with a flag write
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         period_irq <= PFC_RST_PERIOD;
      end else begin
         period_irq <= period_flags & period_ie;
      end
   end

   // value written to an indicator that clears it: one only in legacy mode
   assign clr_level = LOW_DENSITY & legacy_compat_select;

   genvar g;
   for (g = 0; g < 2; g++) begin : g_chan
      localparam int B = g * PFC_CH_STRIDE;

      pfc_cap_edge u_edge (
         .clk(clk),
         .rstn(rstn),
         .pin(cap_pin[g]),
         .invert(ctl[g][PFC_F_INV]),
         .rise(rise_raw[g]),
         .fall(fall_raw[g])
      );

      // events only count while capture is enabled
      assign rise_ev[g] = rise_raw[g] & ctl[g][PFC_F_CEN];
      assign fall_ev[g] = fall_raw[g] & ctl[g][PFC_F_CEN];
      assign capif_set[g] = (rise_ev[g] & ctl[g][PFC_F_RIE])
         | (fall_ev[g] & ctl[g][PFC_F_FIE]);
      assign capif_clr[g] = wr_lane(PFC_OFS_CAPCTRL, 2 * g)
         & avs_writedata[B + PFC_F_CAPIF];
      assign rind_clr[g] = wr_lane(PFC_OFS_CAPCTRL, 2 * g)
         & (avs_writedata[B + PFC_F_RIND] == clr_level);
      assign find_clr[g] = wr_lane(PFC_OFS_CAPCTRL, 2 * g)
         & (avs_writedata[B + PFC_F_FIND] == clr_level);

      // plain read/write control nibble
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            ctl[g] <= PFC_RST_CTL;
         end else if (wr_lane(PFC_OFS_CAPCTRL, 2 * g)) begin
            ctl[g] <= avs_writedata[B +: 4];
         end
      end

      // counter snapshots
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rise_snap[g] <= PFC_RST_SNAP;
            fall_snap[g] <= PFC_RST_SNAP;
         end else begin
            if (rise_ev[g]) begin
               rise_snap[g] <= cnt[g];
            end
            if (fall_ev[g]) begin
               fall_snap[g] <= cnt[g];
            end
         end
      end

      // sticky indicators and flag; a new event beats a clear write
      always_ff @(posedge clk or negedge rstn) begin
         if (!rstn) begin
            rind[g] <= 1'b0;
            find[g] <= 1'b0;
            capif[g] <= 1'b0;
         end else begin
            rind[g] <= rise_ev[g] | (rind[g] & ~rind_clr[g]);
            find[g] <= fall_ev[g] | (find[g] & ~find_clr[g]);
            capif[g] <= capif_set[g] | (capif[g] & ~capif_clr[g]);
         end
      end

      chk_rise_snapshot: assert property (
         @(posedge clk) disable iff (!rstn)
         rise_ev[g] |=> (rise_snap[g] == $past(cnt[g])) && rind[g])
         else $error("rising snapshot or indicator wrong");

      chk_fall_snapshot: assert property (
         @(posedge clk) disable iff (!rstn)
         fall_ev[g] |=> (fall_snap[g] == $past(cnt[g])) && find[g])
         else $error("falling snapshot or indicator wrong");

      chk_disabled_hold: assert property (
         @(posedge clk) disable iff (!rstn)
         (!ctl[g][PFC_F_CEN] && !capif[g] && !capif_clr[g])
         |=> $stable(rise_snap[g]) && $stable(fall_snap[g]) && !capif[g])
         else $error("disabled channel updated");

      chk_rise_flag: assert property (
         @(posedge clk) disable iff (!rstn)
         (rise_ev[g] && ctl[g][PFC_F_RIE]) |=> capif[g] ##1 (capif[g] || $past(capif_clr[g])))
         else $error("rising edge did not set capture flag");

      chk_fall_flag: assert property (
         @(posedge clk) disable iff (!rstn)
         (fall_ev[g] && ctl[g][PFC_F_FIE]) |=> capif[g])
         else $error("falling edge did not set capture flag");

      chk_rise_noirq: assert property (
         @(posedge clk) disable iff (!rstn)
         (rise_raw[g] && !ctl[g][PFC_F_RIE] && !capif[g]) |=> !capif[g])
         else $error("rising edge raised interrupt while disabled");

      chk_fall_noirq: assert property (
         @(posedge clk) disable iff (!rstn)
         (fall_raw[g] && !ctl[g][PFC_F_FIE] && !capif[g]) |=> !capif[g])
         else $error("falling edge raised interrupt while disabled");

      chk_flag_w1c: assert property (
         @(posedge clk) disable iff (!rstn)
         (capif_clr[g] && !capif_set[g]) |=> !capif[g])
         else $error("capture flag not cleared by one write");

      chk_ind_clear: assert property (
         @(posedge clk) disable iff (!rstn)
         (rind_clr[g] && !rise_ev[g]) |=> !rind[g])
         else $error("rising indicator not cleared");

      // sticky bits only drop on their own clearing write
      chk_fall_clear: assert property (
         @(posedge clk) disable iff (!rstn)
         (find_clr[g] && !fall_ev[g]) |=> !find[g])
         else $error("falling indicator not cleared");

      chk_rind_keep: assert property (
         @(posedge clk) disable iff (!rstn)
         (rind[g] && !rind_clr[g]) |=> rind[g])
         else $error("rising indicator lost without a clearing write");

      chk_find_keep: assert property (
         @(posedge clk) disable iff (!rstn)
         (find[g] && !find_clr[g]) |=> find[g])
         else $error("falling indicator lost without a clearing write");

      chk_capif_keep: assert property (
         @(posedge clk) disable iff (!rstn)
         (capif[g] && !capif_clr[g]) |=> capif[g])
         else $error("capture flag lost without a one write");
   end

   assign capture_irq = capif;

   // capture control image, reserved bits zero
   always_comb begin
      ccr_word = PFC_RST_RDATA;
      for (int c = 0; c < 2; c++) begin
         ccr_word[c * PFC_CH_STRIDE +: 4] = ctl[c];
         ccr_word[c * PFC_CH_STRIDE + PFC_F_CAPIF] = capif[c];
         ccr_word[c * PFC_CH_STRIDE + PFC_F_RIND] = rind[c];
         ccr_word[c * PFC_CH_STRIDE + PFC_F_FIND] = find[c];
      end
   end

   // read data captured in the wait cycle; unmapped offsets read zero
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         avs_readdata <= PFC_RST_RDATA;
      end else if (avs_read && !ack) begin
         case (avs_address)
            PFC_OFS_LEGACY: avs_readdata <= {31'h0000_0000, legacy_compat_select};
            PFC_OFS_PERIOD_IE: avs_readdata <= {28'h000_0000, period_ie};
            PFC_OFS_PERIOD_FLAGS: avs_readdata <= {28'h000_0000, period_flags};
            PFC_OFS_CAPCTRL: avs_readdata <= ccr_word;
            PFC_OFS_RISE_CH0: avs_readdata <= {16'h0000, rise_snap[0]};
            PFC_OFS_FALL_CH0: avs_readdata <= {16'h0000, fall_snap[0]};
            PFC_OFS_RISE_CH1: avs_readdata <= {16'h0000, rise_snap[1]};
            PFC_OFS_FALL_CH1: avs_readdata <= {16'h0000, fall_snap[1]};
            default: avs_readdata <= PFC_RST_RDATA;
         endcase
      end
   end

   chk_period_gate: assert property (
      @(posedge clk) disable iff (!rstn)
      ##1 (period_irq == ($past(period_flags) & $past(period_ie))))
      else $error("period request not gated by enable");

   chk_bus_wait: assert property (
      @(posedge clk) disable iff (!rstn)
      (req && !ack) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("waitrequest not exactly one cycle");

   chk_legacy_absent: assert property (
      @(posedge clk) disable iff (!rstn)
      !LOW_DENSITY |-> !legacy_compat_select)
      else $error("legacy select set in medium density build");

   chk_period_mask: assert property (
      @(posedge clk) disable iff (!rstn)
      !period_ie[3] |=> !period_irq[3])
      else $error("period request 3 raised while disabled");

   // an idle bus must never be stalled, or a master could hang before asking
   chk_wait_idle: assert property (
      @(posedge clk) disable iff (!rstn)
      !req |-> !avs_waitrequest)
      else $error("waitrequest high without a request");

endmodule
`default_nettype wire

// >>> pfc_capture_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR %0t got %h expected %h", $time, (got), (exp)); end end
module pfc_capture_top_bench;
   import pfc_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [3:0] avs_byteenable = 4'hF;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [15:0] cnt_ch0 = 16'h0000;
   logic [15:0] cnt_ch1 = 16'h0000;
   logic [3:0] zero_hit = 4'h0;
   logic [1:0] level_req = 2'h0;
   logic [1:0] cap_pin;
   logic [3:0] period_irq;
   logic [1:0] capture_irq;
   int fail_count = 0;
   int total_checks = 0;

   pfc_capture_top pfc_capture_top_inst (.clk(clk), .rstn(rstn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .cnt_ch0(cnt_ch0), .cnt_ch1(cnt_ch1),
      .zero_hit(zero_hit), .cap_pin(cap_pin), .period_irq(period_irq),
      .capture_irq(capture_irq));
   pfc_pin_model pfc_pin_model_inst (.clk(clk), .rstn(rstn), .level_req(level_req),
      .cap_pin(cap_pin));

   // 200 mhz clock
   always #2.5 clk = ~clk;

   // one avalon access: request rises after an edge and holds until waitrequest is sampled low
   task automatic bus_xfer(input logic [7:0] a, input logic wr, input logic [31:0] d,
      output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      // read data stands at the accepting edge; one idle edge before the next request
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask

   task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus_xfer(a, 1'b1, d, q);
   endtask

   // read and compare in one go
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus_xfer(a, 1'b0, 32'h0000_0000, q);
      `CHK(q, exp)
   endtask

   // move the pins, then leave time for sync, edge detect and register update
   task automatic pins(input logic [1:0] lv);
      level_req <= lv;
      repeat (8) @(posedge clk);
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // watchdog: the sequence needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      fail_count++;
      end_of_test();
   end

   initial begin
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      // reset values and refused places
      rd_chk(PFC_OFS_PERIOD_FLAGS, 32'h0000_0000);
      rd_chk(PFC_OFS_CAPCTRL, 32'h0000_0000);
      rd_chk(8'h70, 32'h0000_0000);
      bus_write(PFC_OFS_LEGACY, 32'h0000_0001);
      rd_chk(PFC_OFS_LEGACY, 32'h0000_0000);
      // period flags: set by zero pulses, masked irq, independent w1c
      zero_hit <= 4'hD;
      @(posedge clk);
      zero_hit <= 4'h0;
      rd_chk(PFC_OFS_PERIOD_FLAGS, 32'h0000_000D);
      `CHK(period_irq, 4'h0)
      bus_write(PFC_OFS_PERIOD_IE, 32'h0000_0001);
      repeat (2) @(posedge clk);
      @(negedge clk);
      `CHK(period_irq, 4'h1)
      @(posedge clk);
      bus_write(PFC_OFS_PERIOD_FLAGS, 32'h0000_0002);
      rd_chk(PFC_OFS_PERIOD_FLAGS, 32'h0000_000D);
      bus_write(PFC_OFS_PERIOD_FLAGS, 32'h0000_0004);
      rd_chk(PFC_OFS_PERIOD_FLAGS, 32'h0000_0009);
      bus_write(PFC_OFS_PERIOD_FLAGS, 32'h0000_0000);
      rd_chk(PFC_OFS_PERIOD_FLAGS, 32'h0000_0009);
      bus_write(PFC_OFS_PERIOD_IE, 32'h0000_0008);
      @(negedge clk);
      `CHK(period_irq, 4'h8)
      @(posedge clk);
      // ch0 rising capture with rising irq enabled
      cnt_ch0 <= 16'h1234;
      bus_write(PFC_OFS_CAPCTRL, 32'h0000_000A);
      pins(2'h1);
      rd_chk(PFC_OFS_RISE_CH0, 32'h0000_1234);
      rd_chk(PFC_OFS_CAPCTRL, 32'h0000_005A);
      `CHK(capture_irq, 2'h1)
      // clear the flag, keep the indicator by writing one to it
      bus_write(PFC_OFS_CAPCTRL, 32'h0000_005A);
      rd_chk(PFC_OFS_CAPCTRL, 32'h0000_004A);
      `CHK(capture_irq, 2'h0)
      // falling edge with falling irq off: snapshot and indicator only
      cnt_ch0 <= 16'h00F0;
      pins(2'h0);
      rd_chk(PFC_OFS_FALL_CH0, 32'h0000_00F0);
      rd_chk(PFC_OFS_CAPCTRL, 32'h0000_00CA);
      `CHK(capture_irq, 2'h0)
      bus_write(PFC_OFS_CAPCTRL, 32'h0000_000A);
      rd_chk(PFC_OFS_CAPCTRL, 32'h0000_000A);
      // ch1 inverted: a rising pin is a falling event
      cnt_ch1 <= 16'hBEEF;
      bus_write(PFC_OFS_CAPCTRL, 32'h000D_0006);
      pins(2'h2);
      rd_chk(PFC_OFS_FALL_CH1, 32'h0000_BEEF);
      rd_chk(PFC_OFS_RISE_CH1, 32'h0000_0000);
      rd_chk(PFC_OFS_CAPCTRL, 32'h009D_0006);
      `CHK(capture_irq, 2'h2)
      // ch0 with capture disabled: no snapshot, no flag
      cnt_ch0 <= 16'h5555;
      pins(2'h3);
      rd_chk(PFC_OFS_RISE_CH0, 32'h0000_1234);
      `CHK(capture_irq, 2'h2)
      // ch1 inverted: a falling pin is a rising event, rising irq off
      bus_write(PFC_OFS_CAPCTRL, 32'h001D_0006);
      `CHK(capture_irq, 2'h0)
      cnt_ch1 <= 16'h0ACE;
      pins(2'h1);
      rd_chk(PFC_OFS_RISE_CH1, 32'h0000_0ACE);
      rd_chk(PFC_OFS_CAPCTRL, 32'h004D_0006);
      `CHK(capture_irq, 2'h0)
      end_of_test();
   end
endmodule
`default_nettype wire

// >>> pfc_period_flags.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_period_flags
   import pfc_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // counter zero pulses and software clear mask
   input wire logic [3:0] set_pulse,
   input wire logic [3:0] clr_mask,
   // sticky flags
   output logic [3:0] flags
);

   // set wins over a clear in the same cycle so no zero crossing is lost
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         flags <= PFC_RST_PERIOD;
      end else begin
         flags <= set_pulse | (flags & ~clr_mask);
      end
   end

   chk_flag_set: assert property (
      @(posedge clk) disable iff (!rstn)
      set_pulse[0] |=> flags[0])
      else $error("period flag 0 not set on zero");

   chk_flag_clear: assert property (
      @(posedge clk) disable iff (!rstn)
      (clr_mask[1] && !clr_mask[2] && !set_pulse[1] && flags[2]) |=> (!flags[1] && flags[2]))
      else $error("period flag clear wrong or not independent");

   chk_flag_hold: assert property (
      @(posedge clk) disable iff (!rstn)
      (flags[3] && !clr_mask[3]) |=> flags[3])
      else $error("period flag lost without a one write");

endmodule
`default_nettype wire

// >>> pfc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none
module pfc_pin_model
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // requested pin levels from the bench
   input wire logic [1:0] level_req,
   // gpio pins towards the capture block
   output logic [1:0] cap_pin
);
   // pins are driven by a push-pull gpio; they only move just after a rising edge
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cap_pin <= 2'h0;
      end else begin
         cap_pin <= level_req;
      end
   end
endmodule
`default_nettype wire

// >>> pfc_pkg.sv
package pfc_pkg;

   // register byte offsets
   localparam logic [7:0] PFC_OFS_LEGACY = 8'h3C;
   localparam logic [7:0] PFC_OFS_PERIOD_IE = 8'h40;
   localparam logic [7:0] PFC_OFS_PERIOD_FLAGS = 8'h44;
   localparam logic [7:0] PFC_OFS_CAPCTRL = 8'h50;
   localparam logic [7:0] PFC_OFS_RISE_CH0 = 8'h58;
   localparam logic [7:0] PFC_OFS_FALL_CH0 = 8'h5C;
   localparam logic [7:0] PFC_OFS_RISE_CH1 = 8'h60;
   localparam logic [7:0] PFC_OFS_FALL_CH1 = 8'h64;

   // capture control field positions within one channel half
   localparam int PFC_F_INV = 0;
   localparam int PFC_F_RIE = 1;
   localparam int PFC_F_FIE = 2;
   localparam int PFC_F_CEN = 3;
   localparam int PFC_F_CAPIF = 4;
   localparam int PFC_F_RIND = 6;
   localparam int PFC_F_FIND = 7;
   localparam int PFC_CH_STRIDE = 16;

   // widths and reset values
   localparam int PFC_CNT_W = 16;
   localparam logic [15:0] PFC_RST_SNAP = 16'h0000;
   localparam logic [3:0] PFC_RST_CTL = 4'h0;
   localparam logic [3:0] PFC_RST_PERIOD = 4'h0;
   localparam logic [31:0] PFC_RST_RDATA = 32'h0000_0000;

endpackage
